/* File: rtl/lcgis_map.vh */
// What this block does
// - five-bit read/write field in bits 4..0 picks fourth data input source
// - bits 7..5 of the fourth-input selector read zero, writes ignored
// - selectors and term bits unknown at power-up, kept across other resets
// - gate 1 odd bits 7,5,3,1 enable true inputs 4,3,2,1
// - gate 1 even bits 6,4,2,0 enable inverted inputs 4,3,2,1
// - gate 2 register uses the same odd-true, even-inverted layout
// - gate 3 register uses the same odd-true, even-inverted layout
// - cleared bit excludes its term; true and inverted enabled independently
// - each gate output passes its own invert control before the mode logic
//
// Purpose: register map and field layout of the gate input select block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only
`ifndef LCGIS_MAP_VH
`define LCGIS_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LCGIS_OFF_D4SEL 12'h000
`define LCGIS_OFF_GLS1 12'h004
`define LCGIS_OFF_GLS2 12'h008
`define LCGIS_OFF_GLS3 12'h00C
`define LCGIS_OFF_GPOL 12'h010
`define LCGIS_OFF_STAT 12'h014

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define LCGIS_SRC_W 5
`define LCGIS_SRC_LSB 0
`define LCGIS_GLS_W 8
`define LCGIS_POL_W 3
`define LCGIS_BIT_IN1_INV 0
`define LCGIS_BIT_IN1_TRUE 1
`define LCGIS_BIT_IN2_INV 2
`define LCGIS_BIT_IN2_TRUE 3
`define LCGIS_BIT_IN3_INV 4
`define LCGIS_BIT_IN3_TRUE 5
`define LCGIS_BIT_IN4_INV 6
`define LCGIS_BIT_IN4_TRUE 7

// ----------------------------------------------------------------
// status word layout and reset values
// ----------------------------------------------------------------
`define LCGIS_STAT_RAW_LSB 0
`define LCGIS_STAT_OUT_LSB 4
`define LCGIS_STAT_D4_BIT 8
`define LCGIS_RST_PRDATA 32'h00000000
`define LCGIS_RST_GATES 3'h0

`endif

/* File: rtl/lcgis_top.v */
// Purpose: gate input selection for one configurable logic cell
// Assumes: source and data inputs synchronous to pclk
// Notes: select registers carry no reset so they survive presetn
`timescale 1ns/100ps
`include "lcgis_map.vh"

module lcgis_top #(
  parameter NUM_SRC = 32,
  parameter ADDR_W = 12
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // data inputs of the cell
  input wire [NUM_SRC-1:0] src_in,
  input wire data1_in,
  input wire data2_in,
  input wire data3_in,
  // gate outputs toward the mode logic
  output reg gate_one_out,
  output reg gate_two_out,
  output reg gate_three_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // or of every enabled term; an empty selection yields zero
  // terms come in already split into true and inverted copies, so each
  // enable bit meets exactly the one term that sits at its position
  function gate_or;
    input [`LCGIS_GLS_W-1:0] en;
    input [`LCGIS_GLS_W-1:0] terms;
    begin
      gate_or = (en[`LCGIS_BIT_IN4_TRUE] & terms[`LCGIS_BIT_IN4_TRUE]) |
                (en[`LCGIS_BIT_IN4_INV] & terms[`LCGIS_BIT_IN4_INV]) |
                (en[`LCGIS_BIT_IN3_TRUE] & terms[`LCGIS_BIT_IN3_TRUE]) |
                (en[`LCGIS_BIT_IN3_INV] & terms[`LCGIS_BIT_IN3_INV]) |
                (en[`LCGIS_BIT_IN2_TRUE] & terms[`LCGIS_BIT_IN2_TRUE]) |
                (en[`LCGIS_BIT_IN2_INV] & terms[`LCGIS_BIT_IN2_INV]) |
                (en[`LCGIS_BIT_IN1_TRUE] & terms[`LCGIS_BIT_IN1_TRUE]) |
                (en[`LCGIS_BIT_IN1_INV] & terms[`LCGIS_BIT_IN1_INV]);
    end
  endfunction

  // word-aligned match of the bus address against one offset
  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [11:0] off;
    begin
      addr_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    end
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [`LCGIS_SRC_W-1:0] fourth_input_source_field;
  reg [`LCGIS_GLS_W-1:0] gate1_term_select;
  reg [`LCGIS_GLS_W-1:0] gate2_term_select;
  reg [`LCGIS_GLS_W-1:0] gate3_term_select;
  reg [`LCGIS_POL_W-1:0] gate_polarity;
  reg [31:0] next_prdata;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setup_phase;
  wire access_phase;
  wire wr_en;
  wire lane0;
  wire hit_d4sel;
  wire hit_gls1;
  wire hit_gls2;
  wire hit_gls3;
  wire hit_gpol;
  wire hit_stat;
  wire hit_any;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  // zero wait states: every access completes in its first access cycle
  assign pready = access_phase;
  assign lane0 = pstrb[0];
  assign hit_d4sel = addr_hit(paddr, `LCGIS_OFF_D4SEL);
  assign hit_gls1 = addr_hit(paddr, `LCGIS_OFF_GLS1);
  assign hit_gls2 = addr_hit(paddr, `LCGIS_OFF_GLS2);
  assign hit_gls3 = addr_hit(paddr, `LCGIS_OFF_GLS3);
  assign hit_gpol = addr_hit(paddr, `LCGIS_OFF_GPOL);
  assign hit_stat = addr_hit(paddr, `LCGIS_OFF_STAT);
  assign hit_any = hit_d4sel | hit_gls1 | hit_gls2 | hit_gls3 | hit_gpol | hit_stat;
  // unmapped addresses and writes to the read-only status flag an error
  assign pslverr = access_phase & (~hit_any | (pwrite & hit_stat));
  // writes take effect only at the completing edge
  assign wr_en = access_phase & pwrite & lane0;

  // one strobe per register; a write with lane 0 off is dropped silently
  wire wr_d4sel;
  wire wr_gls1;
  wire wr_gls2;
  wire wr_gls3;
  wire wr_gpol;

  assign wr_d4sel = wr_en & hit_d4sel;
  assign wr_gls1 = wr_en & hit_gls1;
  assign wr_gls2 = wr_en & hit_gls2;
  assign wr_gls3 = wr_en & hit_gls3;
  assign wr_gpol = wr_en & hit_gpol;

  // write data cut to each field; upper lane bits never reach storage
  wire [`LCGIS_SRC_W-1:0] wdata_src;
  wire [`LCGIS_GLS_W-1:0] wdata_gls;
  wire [`LCGIS_POL_W-1:0] wdata_pol;

  assign wdata_src = pwdata[`LCGIS_SRC_LSB+`LCGIS_SRC_W-1:`LCGIS_SRC_LSB];
  assign wdata_gls = pwdata[`LCGIS_GLS_W-1:0];
  assign wdata_pol = pwdata[`LCGIS_POL_W-1:0];

  // ----------------------------------------------------------------
  // data terms
  // ----------------------------------------------------------------
  wire in1_true_term;
  wire in1_inv_term;
  wire in2_true_term;
  wire in2_inv_term;
  wire in3_true_term;
  wire in3_inv_term;
  wire in4_true_term;
  wire in4_inv_term;
  wire data4_value;

  // out-of-range selector codes read the source as zero
  assign data4_value = (fourth_input_source_field < NUM_SRC) ?
                       src_in[fourth_input_source_field] : 1'b0;
  assign in1_true_term = data1_in;
  assign in1_inv_term = ~data1_in;
  assign in2_true_term = data2_in;
  assign in2_inv_term = ~data2_in;
  assign in3_true_term = data3_in;
  assign in3_inv_term = ~data3_in;
  assign in4_true_term = data4_value;
  assign in4_inv_term = ~data4_value;

  // all eight terms in term-select bit order, true copy on the odd bit
  wire [`LCGIS_GLS_W-1:0] term_vec;

  assign term_vec = {in4_true_term, in4_inv_term, in3_true_term, in3_inv_term,
                     in2_true_term, in2_inv_term, in1_true_term, in1_inv_term};

  // ----------------------------------------------------------------
  // per-gate term enables
  // ----------------------------------------------------------------
  wire g1_in4_true_en;
  wire g1_in4_inv_en;
  wire g1_in3_true_en;
  wire g1_in3_inv_en;
  wire g1_in2_true_en;
  wire g1_in2_inv_en;
  wire g1_in1_true_en;
  wire g1_in1_inv_en;
  wire g2_in4_true_en;
  wire g2_in4_inv_en;
  wire g2_in3_true_en;
  wire g2_in3_inv_en;
  wire g2_in2_true_en;
  wire g2_in2_inv_en;
  wire g2_in1_true_en;
  wire g2_in1_inv_en;
  wire g3_in4_true_en;
  wire g3_in4_inv_en;
  wire g3_in3_true_en;
  wire g3_in3_inv_en;
  wire g3_in2_true_en;
  wire g3_in2_inv_en;
  wire g3_in1_true_en;
  wire g3_in1_inv_en;
  wire [`LCGIS_GLS_W-1:0] gate1_en;
  wire [`LCGIS_GLS_W-1:0] gate2_en;
  wire [`LCGIS_GLS_W-1:0] gate3_en;

  // gate 1: odd bits pick true copies, even bits inverted copies
  assign g1_in4_true_en = gate1_term_select[`LCGIS_BIT_IN4_TRUE];
  assign g1_in4_inv_en = gate1_term_select[`LCGIS_BIT_IN4_INV];
  assign g1_in3_true_en = gate1_term_select[`LCGIS_BIT_IN3_TRUE];
  assign g1_in3_inv_en = gate1_term_select[`LCGIS_BIT_IN3_INV];
  assign g1_in2_true_en = gate1_term_select[`LCGIS_BIT_IN2_TRUE];
  assign g1_in2_inv_en = gate1_term_select[`LCGIS_BIT_IN2_INV];
  assign g1_in1_true_en = gate1_term_select[`LCGIS_BIT_IN1_TRUE];
  assign g1_in1_inv_en = gate1_term_select[`LCGIS_BIT_IN1_INV];

  // gate 2 follows the gate 1 layout
  assign g2_in4_true_en = gate2_term_select[`LCGIS_BIT_IN4_TRUE];
  assign g2_in4_inv_en = gate2_term_select[`LCGIS_BIT_IN4_INV];
  assign g2_in3_true_en = gate2_term_select[`LCGIS_BIT_IN3_TRUE];
  assign g2_in3_inv_en = gate2_term_select[`LCGIS_BIT_IN3_INV];
  assign g2_in2_true_en = gate2_term_select[`LCGIS_BIT_IN2_TRUE];
  assign g2_in2_inv_en = gate2_term_select[`LCGIS_BIT_IN2_INV];
  assign g2_in1_true_en = gate2_term_select[`LCGIS_BIT_IN1_TRUE];
  assign g2_in1_inv_en = gate2_term_select[`LCGIS_BIT_IN1_INV];

  // gate 3 follows the gate 1 layout
  assign g3_in4_true_en = gate3_term_select[`LCGIS_BIT_IN4_TRUE];
  assign g3_in4_inv_en = gate3_term_select[`LCGIS_BIT_IN4_INV];
  assign g3_in3_true_en = gate3_term_select[`LCGIS_BIT_IN3_TRUE];
  assign g3_in3_inv_en = gate3_term_select[`LCGIS_BIT_IN3_INV];
  assign g3_in2_true_en = gate3_term_select[`LCGIS_BIT_IN2_TRUE];
  assign g3_in2_inv_en = gate3_term_select[`LCGIS_BIT_IN2_INV];
  assign g3_in1_true_en = gate3_term_select[`LCGIS_BIT_IN1_TRUE];
  assign g3_in1_inv_en = gate3_term_select[`LCGIS_BIT_IN1_INV];

  // enables regrouped in bit order; each bit gates only its own term
  assign gate1_en = {g1_in4_true_en, g1_in4_inv_en, g1_in3_true_en, g1_in3_inv_en,
                     g1_in2_true_en, g1_in2_inv_en, g1_in1_true_en, g1_in1_inv_en};
  assign gate2_en = {g2_in4_true_en, g2_in4_inv_en, g2_in3_true_en, g2_in3_inv_en,
                     g2_in2_true_en, g2_in2_inv_en, g2_in1_true_en, g2_in1_inv_en};
  assign gate3_en = {g3_in4_true_en, g3_in4_inv_en, g3_in3_true_en, g3_in3_inv_en,
                     g3_in2_true_en, g3_in2_inv_en, g3_in1_true_en, g3_in1_inv_en};

  // ----------------------------------------------------------------
  // gate combination
  // ----------------------------------------------------------------
  wire gate1_raw;
  wire gate2_raw;
  wire gate3_raw;
  wire gate_one_invert;
  wire next_gate_one;
  wire next_gate_two;
  wire next_gate_three;

  // true and inverted copies share one polarity-free or network
  assign gate1_raw = gate_or(gate1_en, term_vec);
  assign gate2_raw = gate_or(gate2_en, term_vec);
  assign gate3_raw = gate_or(gate3_en, term_vec);

  // per-gate invert applied after the or
  assign gate_one_invert = gate_polarity[0];
  assign next_gate_one = gate1_raw ^ gate_one_invert;
  assign next_gate_two = gate2_raw ^ gate_polarity[1];
  assign next_gate_three = gate3_raw ^ gate_polarity[2];

  // ----------------------------------------------------------------
  // select registers
  // ----------------------------------------------------------------

  // no reset term: the value survives presetn and is unknown at power-up
  always @(posedge pclk) begin
    if (wr_d4sel) begin
      // upper bits of the byte are dropped here
      fourth_input_source_field <= wdata_src;
    end
  end

  // gate 1 term enables
  always @(posedge pclk) begin
    if (wr_gls1) begin
      gate1_term_select <= wdata_gls;
    end
  end

  // gate 2 term enables
  always @(posedge pclk) begin
    if (wr_gls2) begin
      gate2_term_select <= wdata_gls;
    end
  end

  // gate 3 term enables
  always @(posedge pclk) begin
    if (wr_gls3) begin
      gate3_term_select <= wdata_gls;
    end
  end

  // gate polarity bits follow the same keep-across-reset behaviour
  always @(posedge pclk) begin
    if (wr_gpol) begin
      gate_polarity <= wdata_pol;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  // read word chosen during setup so prdata is a flop in the access cycle
  always @* begin
    next_prdata = 32'h00000000;
    if (hit_d4sel) begin
      next_prdata[`LCGIS_SRC_W-1:0] = fourth_input_source_field;
    end else if (hit_gls1) begin
      next_prdata[`LCGIS_GLS_W-1:0] = gate1_term_select;
    end else if (hit_gls2) begin
      next_prdata[`LCGIS_GLS_W-1:0] = gate2_term_select;
    end else if (hit_gls3) begin
      next_prdata[`LCGIS_GLS_W-1:0] = gate3_term_select;
    end else if (hit_gpol) begin
      next_prdata[`LCGIS_POL_W-1:0] = gate_polarity;
    end else if (hit_stat) begin
      next_prdata[`LCGIS_STAT_RAW_LSB] = gate1_raw;
      next_prdata[`LCGIS_STAT_RAW_LSB+1] = gate2_raw;
      next_prdata[`LCGIS_STAT_RAW_LSB+2] = gate3_raw;
      next_prdata[`LCGIS_STAT_OUT_LSB] = gate_one_out;
      next_prdata[`LCGIS_STAT_OUT_LSB+1] = gate_two_out;
      next_prdata[`LCGIS_STAT_OUT_LSB+2] = gate_three_out;
      next_prdata[`LCGIS_STAT_D4_BIT] = data4_value;
    end
  end

  // capture on setup; hold through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `LCGIS_RST_PRDATA;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end else if (setup_phase) begin
      prdata <= `LCGIS_RST_PRDATA;
    end
  end

  // ----------------------------------------------------------------
  // gate output flops
  // ----------------------------------------------------------------

  // registered so the mode logic sees glitch-free gates; costs one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_one_out <= 1'b0;
      gate_two_out <= 1'b0;
      gate_three_out <= 1'b0;
    end else begin
      gate_one_out <= next_gate_one;
      gate_two_out <= next_gate_two;
      gate_three_out <= next_gate_three;
    end
  end

endmodule // lcgis_top

/* File: sim/lcgis_asserts.sv */
// Purpose: port-level checks for lcgis_top
// Assumes: 12-bit paddr, zero-wait slave
// Notes: gate 1 is rebuilt from shadow copies of bus writes
`timescale 1ns/100ps
`include "lcgis_map.vh"
module lcgis_asserts #(
  parameter NUM_SRC = 32,
  parameter ADDR_W = 12
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [NUM_SRC-1:0] src_in,
  input wire data1_in,
  input wire data2_in,
  input wire data3_in,
  input wire gate_one_out
);
  // ----------------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------------
  wire rd = psel & penable & !pwrite;
  wire wr = psel & penable & pwrite & pstrb[0];
  wire [11:0] off = {paddr[11:2], 2'h0};
  reg [4:0] s_src;
  reg [7:0] s_gls;
  reg s_pol;
  reg [2:0] s_ok;
  wire d4 = (s_src < NUM_SRC) ? src_in[s_src] : 1'b0;
  wire [7:0] t = {d4, ~d4, data3_in, ~data3_in, data2_in, ~data2_in, data1_in, ~data1_in};
  wire exp1 = (|(s_gls & t)) ^ s_pol;
  // shadows unreset like the design registers
  always @(posedge pclk) begin
    if (wr && off == `LCGIS_OFF_D4SEL) s_src <= pwdata[4:0];
    if (wr && off == `LCGIS_OFF_GLS1) s_gls <= pwdata[7:0];
    if (wr && off == `LCGIS_OFF_GPOL) s_pol <= pwdata[0];
  end
  // trust flags drop at reset: cautious, checks resume after rewrite
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) s_ok <= 3'h0;
    else if (wr) s_ok <= s_ok | {off == `LCGIS_OFF_GPOL, off == `LCGIS_OFF_GLS1, off == 12'h0};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_src_readback: assert property (rd && off == 12'h0 && s_ok[0] |-> prdata[4:0] == s_src)
    else $error("source readback");
  a_src_upper_zero: assert property (rd && off == 12'h0 |-> prdata[31:5] == 27'h0)
    else $error("source upper bits");
  a_gls_readback: assert property (rd && off == `LCGIS_OFF_GLS1 && s_ok[1] |->
    prdata[7:0] == s_gls)
    else $error("term readback");
  a_gls_upper_zero: assert property (rd && off > 12'h0 && off < 12'h010 |->
    prdata[31:8] == 24'h0)
    else $error("term upper bits");
  a_map_no_err: assert property (rd && off < 12'h010 |-> !pslverr)
    else $error("mapped read refused");
  a_gate_one_calc: assert property (&s_ok |=> gate_one_out == $past(exp1))
    else $error("gate 1 value");
  a_gate_none_low: assert property (&s_ok && s_gls == 8'h00 && !s_pol |=> !gate_one_out)
    else $error("gate 1 not low");
  a_gate_pol_high: assert property (&s_ok && s_gls == 8'h00 && s_pol |=> gate_one_out)
    else $error("gate 1 not inverted");
  c_write: cover property (wr);
  c_refuse: cover property (rd && pslverr);
  c_gate_high: cover property (&s_ok && gate_one_out);
endmodule // lcgis_asserts

bind lcgis_top lcgis_asserts #(.NUM_SRC(NUM_SRC), .ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .src_in(src_in),
  .data1_in(data1_in), .data2_in(data2_in), .data3_in(data3_in), .gate_one_out(gate_one_out));

/* File: sim/logic_cell_gate_input_select_tb_top.sv */
// Purpose: self-checking bench for lcgis_top
// Assumes: zero-wait apb slave, gates lag settings by one edge
// Notes: data 4 comes from src_in bit 19 in the gate sweep
`timescale 1ns/100ps
`include "lcgis_map.vh"
module logic_cell_gate_input_select_tb_top;
  // ----------------------------------------------------------------
  // stimulus and checking
  // ----------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, src_in = 32'h00000000, prdata, rv;
  logic [3:0] pstrb = 4'hF;
  logic data1_in = 1'b0, data2_in = 1'b0, data3_in = 1'b0, pready, pslverr, ev;
  logic gate_one_out, gate_two_out, gate_three_out;
  logic [7:0] tbl [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h00, 8'h03};
  logic [2:0] pols [3] = '{3'h0, 3'h5, 3'h2};
  integer error_cnt = 0, n_compared = 0;
  lcgis_top #(.NUM_SRC(32), .ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in), .data1_in(data1_in),
    .data2_in(data2_in), .data3_in(data3_in), .gate_one_out(gate_one_out),
    .gate_two_out(gate_two_out), .gate_three_out(gate_three_out));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task conclude;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // one transfer; pready awaited under a bound, request held till then
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    integer i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 16) begin
      chkb("pready wait", 1'b1, 1'b0);
      conclude;
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(nm, e, rv);
  endtask
  function logic ge(input logic [7:0] s, input logic [3:0] t, input logic p);
    ge = (|(s & {t[3], ~t[3], t[2], ~t[2], t[1], ~t[1], t[0], ~t[0]})) ^ p;
  endfunction
  task t_src;
    integer c;
    apb(1'b1, `LCGIS_OFF_GLS1, 32'h80, 4'hF);
    apb(1'b1, `LCGIS_OFF_GPOL, 32'h0, 4'hF);
    for (c = 0; c < 32; c++) begin
      apb(1'b1, `LCGIS_OFF_D4SEL, c, 4'hF);
      src_in <= 32'h1 << c;
      repeat (2) @(posedge pclk);
      chkb("d4 one hot", 1'b1, gate_one_out);
      src_in <= ~(32'h1 << c);
      repeat (2) @(posedge pclk);
      chkb("d4 one cold", 1'b0, gate_one_out);
    end
  endtask
  // rotated tables keep the three gates on different settings
  task t_gates;
    integer p, k, n;
    apb(1'b1, `LCGIS_OFF_D4SEL, 32'h13, 4'hF);
    for (p = 0; p < 3; p++) begin
      apb(1'b1, `LCGIS_OFF_GPOL, {29'h0, pols[p]}, 4'hF);
      for (k = 0; k < 10; k++) begin
        apb(1'b1, `LCGIS_OFF_GLS1, {24'h0, tbl[k]}, 4'hF);
        apb(1'b1, `LCGIS_OFF_GLS2, {24'h0, tbl[(k + 3) % 10]}, 4'hF);
        apb(1'b1, `LCGIS_OFF_GLS3, {24'h0, tbl[(k + 7) % 10]}, 4'hF);
        for (n = 0; n < 16; n++) begin
          src_in <= n[3] ? 32'h00080000 : 32'hFFF7FFFF;
          data1_in <= n[0];
          data2_in <= n[1];
          data3_in <= n[2];
          repeat (2) @(posedge pclk);
          chkb("gate 1", ge(tbl[k], n[3:0], pols[p][0]), gate_one_out);
          chkb("gate 2", ge(tbl[(k + 3) % 10], n[3:0], pols[p][1]), gate_two_out);
          chkb("gate 3", ge(tbl[(k + 7) % 10], n[3:0], pols[p][2]), gate_three_out);
        end
      end
    end
  endtask
  task rdall;
    rdchk(`LCGIS_OFF_D4SEL, 32'h1F, "d4 select");
    rdchk(`LCGIS_OFF_GLS1, 32'h5A, "gate 1 terms");
    rdchk(`LCGIS_OFF_GLS2, 32'hA5, "gate 2 terms");
    rdchk(`LCGIS_OFF_GLS3, 32'hC3, "gate 3 terms");
    rdchk(`LCGIS_OFF_GPOL, 32'h5, "gate polarity");
  endtask
  task t_retain;
    apb(1'b1, `LCGIS_OFF_D4SEL, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, `LCGIS_OFF_GLS1, 32'hFFFFFF5A, 4'hF);
    apb(1'b1, `LCGIS_OFF_GLS2, 32'h000000A5, 4'hF);
    apb(1'b1, `LCGIS_OFF_GLS2, 32'h000000FF, 4'hE);
    apb(1'b1, `LCGIS_OFF_GLS3, 32'h000000C3, 4'hF);
    apb(1'b1, `LCGIS_OFF_GPOL, 32'hFFFFFFFD, 4'hF);
    rdall;
    rdchk(12'h040, 32'h0, "unmapped data");
    chkb("unmapped err", 1'b1, ev);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chkb("gate in reset", 1'b0, gate_one_out);
    presetn <= 1'b1;
    rdall;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_src;
    t_gates;
    t_retain;
    conclude;
  end
endmodule // logic_cell_gate_input_select_tb_top
